// File: hdl/cim_params.svh
// register map, field positions, reset values and mode codes of the counter input block
// What this block does
// - measure one gate period after arming
// - count source edges between gate edges
// - single edge: up on A rise, down on A fall, both only with B low
// - double edge: count both edges of A
// - quadruple edge: count every A and B edge
// - index high in chosen phase loads reload
// - count step first, reload after it
// - reload completes within one timebase period
// - two pulse: A rise up, B rise down
// - position counts from arm, cumulative
// - sample clock captures count, no clearing
// - sample clock edge polarity selectable
// - aux active edge starts separation count
// - further aux edges ignored while counting
// - gate active edge stops, count into fifo
// - aux and gate polarity independently selectable
// - single separation keeps one count, then done
// - implicit buffered: new interval, every count streamed
// - sample clocked: fifo write at sample edge
// - overrun unless gate and aux between samples
`ifndef CIM_PARAMS_SVH
`define CIM_PARAMS_SVH
`define CIM_OFF_CTRL 8'h00
`define CIM_OFF_RELOAD 8'h04
`define CIM_OFF_COUNT 8'h08
`define CIM_OFF_LATCH 8'h0c
`define CIM_OFF_STATUS 8'h10
`define CIM_OFF_DATA 8'h14
`define CIM_CTRL_ARM 0
`define CIM_CTRL_MODE_LO 1
`define CIM_CTRL_MODE_HI 3
`define CIM_CTRL_SRC_FALL 4
`define CIM_CTRL_GATE_FALL 5
`define CIM_CTRL_AUX_FALL 6
`define CIM_CTRL_SAMP_FALL 7
`define CIM_CTRL_POS_BUF 8
`define CIM_CTRL_PH_LO 9
`define CIM_CTRL_PH_HI 10
`define CIM_CTRL_REL_EN 11
`define CIM_CTRL_RST 12'h000
`define CIM_RELOAD_RST 32'h0000_0000
`define CIM_ST_ARMED 0
`define CIM_ST_DONE 1
`define CIM_ST_OVERRUN 2
`define CIM_ST_OVERFLOW 3
`define CIM_ST_EMPTY 4
`define CIM_ST_LEVEL_LO 8
`define CIM_MODE_PERIOD 3'h0
`define CIM_MODE_SINGLE_EDGE 3'h1
`define CIM_MODE_DOUBLE_EDGE 3'h2
`define CIM_MODE_QUAD_EDGE 3'h3
`define CIM_MODE_TWO_PULSE 3'h4
`define CIM_MODE_SEP_SINGLE 3'h5
`define CIM_MODE_SEP_IMPLICIT 3'h6
`define CIM_MODE_SEP_SAMPLED 3'h7
`define CIM_CLK_PERIOD_NS 50
`define CIM_RELOAD_MAX_NS 50
`define CIM_RELOAD_MAX_CYC (`CIM_RELOAD_MAX_NS / `CIM_CLK_PERIOD_NS)
`endif

// File: hdl/cim_pkg.sv
// types shared by the counter input block
package cim_pkg;
	// measurement sequencing
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_WAIT_START,
		ST_COUNT,
		ST_DONE
	} phase_t;
	// input pins as one bundle
	typedef struct packed {
		logic a;
		logic b;
		logic z;
		logic gate;
		logic aux;
		logic src;
		logic samp;
	} pins_t;
	// apb request from the master
	typedef struct packed {
		logic [7:0] paddr;
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] pwdata;
	} apb_req_t;
endpackage

// File: hdl/cim_result_mem.sv
// result store memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module cim_result_mem #(
	parameter int WIDTH = 32,
	parameter int AW = 4
) (
	input wire logic clk,
	input wire logic ce,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic [AW-1:0] rd_addr,
	output logic [WIDTH-1:0] rd_data
);
	// storage words
	logic [WIDTH-1:0] mem [0:(1<<AW)-1];
	// write port and registered read port
	always_ff @(posedge clk) begin
		if (ce) begin
			if (wr_en) begin
				mem[wr_addr] <= wr_data;
			end
			rd_data <= mem[rd_addr];
		end
	end
endmodule
`default_nettype wire

// File: hdl/cim_counter.sv
// counter input measurement: period, position and edge separation
`timescale 1ns/1ps
`default_nettype none
`include "cim_params.svh"
module cim_counter #(
	parameter int CW = 32,
	parameter int AW = 4
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	input wire cim_pkg::apb_req_t apb_req,
	input wire cim_pkg::pins_t pins,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic data_avail
);
	// whole state of the block
	typedef struct packed {
		cim_pkg::phase_t phase;
		logic armed;
		logic [11:0] ctrl;
		logic [CW-1:0] reload;
		logic [CW-1:0] count;
		logic [CW-1:0] latch;
		logic [CW-1:0] pend_val;
		logic pend;
		logic seen_aux;
		logic seen_gate;
		logic overrun;
		logic overflow;
		logic [AW:0] wr_ptr;
		logic [AW:0] rd_ptr;
		cim_pkg::pins_t s1;
		cim_pkg::pins_t s2;
		cim_pkg::pins_t s3;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic avail;
	} state_t;

	state_t st; // registered state
	state_t nx; // next state
	logic [CW-1:0] mem_rd; // fifo head word
	logic push; // fifo write request
	logic [CW-1:0] push_data; // word to store
	logic wr_en; // accepted write
	logic pop; // fifo read completes
	logic [AW:0] level; // words held
	logic full; // no room
	logic empty; // nothing held
	logic [2:0] mode; // selected measurement
	logic src_e; // active source edge
	logic gate_e; // active gate edge
	logic aux_e; // active aux edge
	logic samp_e; // active sample edge
	logic a_rise; // channel a rising
	logic b_rise; // channel b rising
	logic reload_due; // index reload this cycle
	logic [1:0] qstep; // {step, up}
	logic acc; // apb access phase
	logic fin; // apb transfer completes
	logic wr_ctrl; // ctrl written now

	// rising or falling detector on synchronised levels
	function automatic logic edge_hit(input logic cur, input logic prv, input logic fall);
		return fall ? (prv & ~cur) : (cur & ~prv);
	endfunction

	// quadrature step decode from old and new {a,b}
	function automatic logic [1:0] quad_step(input logic [2:0] md, input logic [1:0] o,
		input logic [1:0] c);
		logic [1:0] r;
		logic [1:0] io;
		logic [1:0] ic;
		r = 2'b00;
		io = {o[0], o[1] ^ o[0]};
		ic = {c[0], c[1] ^ c[0]};
		case (md)
			`CIM_MODE_SINGLE_EDGE: begin
				// up on a rise with b low, down on a fall with b low
				if (c[1] & ~o[1] & ~c[0]) begin
					r = 2'b11;
				end else if (~c[1] & o[1] & ~c[0]) begin
					r = 2'b10;
				end
			end
			`CIM_MODE_DOUBLE_EDGE: begin
				// both edges of a, direction from b
				if (c[1] ^ o[1]) begin
					r = {1'b1, c[1] ^ c[0]};
				end
			end
			`CIM_MODE_QUAD_EDGE: begin
				// one gray step forward or back
				if (ic == 2'(io + 2'd1)) begin
					r = 2'b11;
				end else if (io == 2'(ic + 2'd1)) begin
					r = 2'b10;
				end
			end
			default: begin
				r = 2'b00;
			end
		endcase
		return r;
	endfunction

	// register read mux
	function automatic logic [31:0] read_word(input logic [7:0] ad, input state_t s,
		input logic [CW-1:0] head, input logic [AW:0] lv);
		logic [31:0] w;
		w = 32'h0000_0000;
		case (ad)
			`CIM_OFF_CTRL: w = 32'(s.ctrl);
			`CIM_OFF_RELOAD: w = 32'(s.reload);
			`CIM_OFF_COUNT: w = 32'(s.count);
			`CIM_OFF_LATCH: w = 32'(s.latch);
			`CIM_OFF_STATUS: begin
				w[`CIM_ST_ARMED] = s.armed;
				w[`CIM_ST_DONE] = (s.phase == cim_pkg::ST_DONE);
				w[`CIM_ST_OVERRUN] = s.overrun;
				w[`CIM_ST_OVERFLOW] = s.overflow;
				w[`CIM_ST_EMPTY] = (lv == '0);
				w[`CIM_ST_LEVEL_LO +: AW+1] = lv;
			end
			`CIM_OFF_DATA: w = (lv == '0) ? 32'h0000_0000 : 32'(head);
			default: w = 32'h0000_0000;
		endcase
		return w;
	endfunction

	// offset decode
	function automatic logic mapped(input logic [7:0] ad);
		return (ad == `CIM_OFF_CTRL) || (ad == `CIM_OFF_RELOAD) || (ad == `CIM_OFF_COUNT) ||
			(ad == `CIM_OFF_LATCH) || (ad == `CIM_OFF_STATUS) || (ad == `CIM_OFF_DATA);
	endfunction

	// fifo bookkeeping and edge strobes
	always_comb begin
		level = AW'(0) + (st.wr_ptr - st.rd_ptr);
		full = (level == (AW+1)'(1 << AW));
		empty = (level == '0);
		mode = st.ctrl[`CIM_CTRL_MODE_HI:`CIM_CTRL_MODE_LO];
		// edges only from second and third stage
		src_e = edge_hit(st.s2.src, st.s3.src, st.ctrl[`CIM_CTRL_SRC_FALL]);
		gate_e = edge_hit(st.s2.gate, st.s3.gate, st.ctrl[`CIM_CTRL_GATE_FALL]);
		aux_e = edge_hit(st.s2.aux, st.s3.aux, st.ctrl[`CIM_CTRL_AUX_FALL]);
		samp_e = edge_hit(st.s2.samp, st.s3.samp, st.ctrl[`CIM_CTRL_SAMP_FALL]);
		a_rise = st.s2.a & ~st.s3.a;
		b_rise = st.s2.b & ~st.s3.b;
		qstep = quad_step(mode, {st.s3.a, st.s3.b}, {st.s2.a, st.s2.b});
		reload_due = st.armed && (mode == `CIM_MODE_SINGLE_EDGE ||
			mode == `CIM_MODE_DOUBLE_EDGE || mode == `CIM_MODE_QUAD_EDGE) &&
			st.ctrl[`CIM_CTRL_REL_EN] && st.s2.z &&
			({st.s2.a, st.s2.b} == st.ctrl[`CIM_CTRL_PH_HI:`CIM_CTRL_PH_LO]);
		acc = apb_req.psel & apb_req.penable;
		fin = acc & st.pready;
		wr_ctrl = fin & apb_req.pwrite & (apb_req.paddr == `CIM_OFF_CTRL);
	end

	// next state
	always_comb begin
		nx = st;
		push = 1'b0;
		push_data = '0;
		pop = 1'b0;
		// two flops ahead of any logic
		nx.s1 = pins;
		nx.s2 = st.s1;
		nx.s3 = st.s2;
		// apb: one wait cycle, answer registered
		nx.pready = acc & ~st.pready;
		if (acc & ~st.pready) begin
			nx.prdata = read_word(apb_req.paddr, st, mem_rd, level);
			nx.pslverr = ~mapped(apb_req.paddr);
		end else if (fin) begin
			nx.prdata = 32'h0000_0000;
			nx.pslverr = 1'b0;
		end
		if (fin & apb_req.pwrite) begin
			case (apb_req.paddr)
				`CIM_OFF_CTRL: begin
					nx.ctrl = apb_req.pwdata[11:0];
					if (apb_req.pwdata[`CIM_CTRL_ARM] & ~st.armed) begin
						nx.armed = 1'b1;
						nx.phase = cim_pkg::ST_WAIT_START;
						nx.count = '0;
						nx.pend = 1'b0;
						nx.seen_aux = 1'b0;
						nx.seen_gate = 1'b0;
					end else if (~apb_req.pwdata[`CIM_CTRL_ARM]) begin
						nx.armed = 1'b0;
						nx.phase = cim_pkg::ST_IDLE;
					end
				end
				`CIM_OFF_RELOAD: nx.reload = CW'(apb_req.pwdata);
				`CIM_OFF_STATUS: begin
					// write one to clear; later sets win
					if (apb_req.pwdata[`CIM_ST_OVERRUN]) begin
						nx.overrun = 1'b0;
					end
					if (apb_req.pwdata[`CIM_ST_OVERFLOW]) begin
						nx.overflow = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end
		pop = fin & ~apb_req.pwrite & (apb_req.paddr == `CIM_OFF_DATA) & ~empty;
		// measurement engine, held while unarmed or while ctrl is written
		if (st.armed & ~wr_ctrl) begin
			case (mode)
				`CIM_MODE_PERIOD: begin
					if (st.phase == cim_pkg::ST_WAIT_START) begin
						if (gate_e) begin
							nx.phase = cim_pkg::ST_COUNT;
							nx.count = '0;
						end
					end else if (st.phase == cim_pkg::ST_COUNT) begin
						if (gate_e) begin
							push = 1'b1;
							push_data = st.count;
							nx.latch = st.count;
							nx.phase = cim_pkg::ST_DONE;
						end else if (src_e) begin
							nx.count = CW'(st.count + 1'b1);
						end
					end
				end
				`CIM_MODE_SINGLE_EDGE, `CIM_MODE_DOUBLE_EDGE, `CIM_MODE_QUAD_EDGE,
				`CIM_MODE_TWO_PULSE: begin
					if (st.ctrl[`CIM_CTRL_POS_BUF] & samp_e) begin
						push = 1'b1;
						push_data = st.count;
					end
					if (mode == `CIM_MODE_TWO_PULSE) begin
						// a rise up, b rise down
						if (a_rise & ~b_rise) begin
							nx.count = CW'(st.count + 1'b1);
						end else if (b_rise & ~a_rise) begin
							nx.count = CW'(st.count - 1'b1);
						end
					end else if (qstep[1]) begin
						nx.count = qstep[0] ? CW'(st.count + 1'b1) : CW'(st.count - 1'b1);
					end
					if (reload_due) begin
						nx.count = st.reload;
					end
				end
				default: begin
					// sample edge checks both edges seen
					if (mode == `CIM_MODE_SEP_SAMPLED && samp_e) begin
						if (~(st.seen_aux & st.seen_gate)) begin
							nx.overrun = 1'b1;
						end
						nx.seen_aux = 1'b0;
						nx.seen_gate = 1'b0;
						if (st.pend) begin
							push = 1'b1;
							push_data = st.pend_val;
							nx.pend = 1'b0;
						end
					end
					if (aux_e) begin
						nx.seen_aux = 1'b1;
					end
					if (gate_e) begin
						nx.seen_gate = 1'b1;
					end
					case (st.phase)
						cim_pkg::ST_WAIT_START: begin
							if (aux_e) begin
								nx.phase = cim_pkg::ST_COUNT;
								nx.count = '0;
							end
						end
						cim_pkg::ST_COUNT: begin
							if (gate_e) begin
								nx.latch = st.count;
								if (mode == `CIM_MODE_SEP_SINGLE) begin
									push = 1'b1;
									push_data = st.count;
									nx.phase = cim_pkg::ST_DONE;
								end else if (mode == `CIM_MODE_SEP_IMPLICIT) begin
									push = 1'b1;
									push_data = st.count;
									nx.phase = cim_pkg::ST_WAIT_START;
								end else begin
									nx.pend = 1'b1;
									nx.pend_val = st.count;
									nx.phase = cim_pkg::ST_WAIT_START;
								end
							end else if (src_e) begin
								nx.count = CW'(st.count + 1'b1);
							end
						end
						default: begin
						end
					endcase
				end
			endcase
		end
		// fifo pointers; overflow is sticky
		if (push & full & ~pop) begin
			nx.overflow = 1'b1;
		end
		if (push & (~full | pop)) begin
			nx.wr_ptr = (AW+1)'(st.wr_ptr + 1'b1);
		end
		if (pop) begin
			nx.rd_ptr = (AW+1)'(st.rd_ptr + 1'b1);
		end
		nx.avail = (nx.wr_ptr != nx.rd_ptr);
	end

	assign wr_en = push & (~full | pop);

	// state register, frozen while ce is low
	always_ff @(posedge clk) begin
		if (srst) begin
			st <= '0;
		end else if (ce) begin
			st <= nx;
		end
	end

	// result words
	cim_result_mem #(
		.WIDTH(CW),
		.AW(AW)
	) u_mem (
		.clk(clk),
		.ce(ce),
		.wr_en(wr_en),
		.wr_addr(st.wr_ptr[AW-1:0]),
		.wr_data(push_data),
		.rd_addr(nx.rd_ptr[AW-1:0]),
		.rd_data(mem_rd)
	);

	assign prdata = st.prdata;
	assign pready = st.pready;
	assign pslverr = st.pslverr;
	assign data_avail = st.avail;

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	sequence s_ce_run;
		ce ##1 ce;
	endsequence
	property p_sync;
		s_ce_run |=> st.s2 == $past(pins, 2);
	endproperty
	a_sync: assert property (p_sync) else $error("input sync depth wrong");

	property p_period_close;
		ce && st.armed && !wr_ctrl && mode == `CIM_MODE_PERIOD &&
			st.phase == cim_pkg::ST_COUNT && gate_e |-> push && push_data == st.count;
	endproperty
	a_period_close: assert property (p_period_close) else $error("period not pushed");

	property p_period_src;
		ce && st.armed && !wr_ctrl && mode == `CIM_MODE_PERIOD &&
			st.phase == cim_pkg::ST_COUNT && src_e && !gate_e |=>
			st.count == CW'($past(st.count) + 1'b1);
	endproperty
	a_period_src: assert property (p_period_src) else $error("source edge missed");

	property p_single_up;
		ce && st.armed && !wr_ctrl && mode == `CIM_MODE_SINGLE_EDGE && !reload_due &&
			a_rise && !st.s2.b && !st.s3.b |=> st.count == CW'($past(st.count) + 1'b1);
	endproperty
	a_single_up: assert property (p_single_up) else $error("single edge up missed");

	property p_quad_hold;
		ce && st.armed && !wr_ctrl && mode == `CIM_MODE_QUAD_EDGE && !reload_due &&
			st.s2.a == st.s3.a && st.s2.b == st.s3.b |=> $stable(st.count);
	endproperty
	a_quad_hold: assert property (p_quad_hold) else $error("count moved idle");

	property p_reload;
		ce && !wr_ctrl && reload_due |=> st.count == $past(st.reload);
	endproperty
	a_reload: assert property (p_reload) else $error("index reload late");

	property p_two_down;
		ce && st.armed && !wr_ctrl && mode == `CIM_MODE_TWO_PULSE && b_rise && !a_rise
			|=> st.count == CW'($past(st.count) - 1'b1);
	endproperty
	a_two_down: assert property (p_two_down) else $error("two pulse down missed");

	property p_aux_ignored;
		ce && st.armed && !wr_ctrl && mode >= `CIM_MODE_SEP_SINGLE &&
			st.phase == cim_pkg::ST_COUNT && aux_e && !gate_e && !src_e |=> $stable(st.count);
	endproperty
	a_aux_ignored: assert property (p_aux_ignored) else $error("aux edge restarted");

	property p_single_stays;
		ce && st.armed && mode == `CIM_MODE_SEP_SINGLE && st.phase == cim_pkg::ST_DONE &&
			!wr_ctrl |=> st.phase == cim_pkg::ST_DONE && $stable(st.latch);
	endproperty
	a_single_stays: assert property (p_single_stays) else $error("single result moved");

	property p_overrun;
		ce && st.armed && !wr_ctrl && mode == `CIM_MODE_SEP_SAMPLED && samp_e &&
			!(st.seen_aux && st.seen_gate) |=> st.overrun;
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun not flagged");
endmodule
`default_nettype wire

// File: testbench/cim_pin_source.sv
// pin source model: encoder channels, gate, aux, source and sample clock
`timescale 1ns/1ps
`default_nettype none
module cim_pin_source (
	input wire logic clk,
	output var cim_pkg::pins_t pins
);
	// every producer idles low until told otherwise
	initial pins = '0;
	// one level change, held four cycles so the two-flop sync sees it
	task automatic lvl(input int n, input logic v);
		@(posedge clk);
		pins[n] <= v;
		repeat (3) @(posedge clk);
	endtask
	// k whole pulses on one pin, one rise and one fall each
	task automatic pulse(input int n, input int k);
		repeat (k) begin
			lvl(n, 1'b1);
			lvl(n, 1'b0);
		end
	endtask
	// whole quadrature cycles ending in phase 00, a leads b when fwd
	task automatic quad(input logic fwd, input int k);
		repeat (k) begin
			lvl(fwd ? 6 : 5, 1'b1);
			lvl(fwd ? 5 : 6, 1'b1);
			lvl(fwd ? 6 : 5, 1'b0);
			lvl(fwd ? 5 : 6, 1'b0);
		end
	endtask
endmodule
`default_nettype wire

// File: testbench/testbench.sv
// self-checking bench for the counter input block
`timescale 1ns/1ps
`default_nettype none
`include "cim_params.svh"
module testbench;
	// register offsets and pin positions in the pin bundle
	localparam logic [7:0] ctl = `CIM_OFF_CTRL;
	localparam logic [7:0] rld = `CIM_OFF_RELOAD;
	localparam logic [7:0] cnt = `CIM_OFF_COUNT;
	localparam logic [7:0] lat = `CIM_OFF_LATCH;
	localparam logic [7:0] sta = `CIM_OFF_STATUS;
	localparam logic [7:0] dat = `CIM_OFF_DATA;
	localparam int pa = 6;
	localparam int pb = 5;
	localparam int pz = 4;
	localparam int pg = 3;
	localparam int px = 2;
	localparam int ps = 1;
	localparam int pp = 0;
	// one expected answer: {pslverr, prdata} and the bits that matter
	typedef struct {logic [32:0] expv; logic [32:0] mask;} note_t;
	logic clk;
	logic srst;
	logic ce;
	cim_pkg::apb_req_t req;
	cim_pkg::pins_t pins;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic data_avail;
	note_t notes[$];
	note_t nt;
	int errors;
	int checks;
	int k;
	logic [31:0] n1;
	logic [31:0] n2;
	logic [31:0] rv;

	cim_counter #(.CW(32), .AW(4)) uut (.clk(clk), .srst(srst), .ce(ce), .apb_req(req),
		.pins(pins), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.data_avail(data_avail));
	cim_pin_source u_pins (.clk(clk), .pins(pins));

	// 50 ns clock
	always #25 clk = ~clk;

	// compare and count
	task automatic check(input logic [32:0] seen, input logic [32:0] expv);
		checks++;
		if (seen !== expv) begin
			errors++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, expv);
		end
	endtask

	// verdict and end of run
	task automatic conclude();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// one apb transfer; expectation is noted before the request goes out
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		input logic [32:0] expv, input logic [32:0] mask);
		int i;
		notes.push_back('{expv, mask});
		@(posedge clk);
		req.paddr <= a;
		req.pwrite <= wr;
		req.pwdata <= wd;
		req.psel <= 1'b1;
		req.penable <= 1'b0;
		@(posedge clk);
		req.penable <= 1'b1;
		i = 0;
		// hold the request until pready is seen at an edge
		do begin
			@(posedge clk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		if (pready !== 1'b1) begin
			errors++;
			$display("wrong value at %0t: no bus answer", $time);
			conclude();
		end else begin
			// release only after the answer edge
			req.psel <= 1'b0;
			req.penable <= 1'b0;
		end
	endtask

	// register read with optional mask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
		bus(1'b0, a, 32'h0, {1'b0, e}, {1'b1, m});
	endtask

	// register write, only the error flag is judged
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic err = 1'b0);
		bus(1'b1, a, d, {err, 32'h0}, {1'b1, 32'h0});
	endtask

	// disarm, then arm in a mode with extra control bits
	task automatic arm(input logic [2:0] mode, input logic [31:0] extra);
		wr(ctl, 32'h0);
		wr(ctl, extra | {28'h0, mode, 1'b1});
	endtask

	// let the last pin change pass sync and update
	task automatic settle();
		repeat (6) @(posedge clk);
	endtask

	// monitor: each answer is judged against the oldest note
	always @(posedge clk) begin
		if (pready === 1'b1) begin
			if (notes.size() == 0) begin
				errors++;
				$display("wrong value at %0t: answer without request", $time);
			end else begin
				nt = notes.pop_front();
				check({pslverr, prdata} & nt.mask, nt.expv & nt.mask);
			end
		end
	end

	// main sequence
	initial begin
		clk = 1'b0;
		srst = 1'b1;
		ce = 1'b1;
		req = '0;
		errors = 0;
		checks = 0;
		void'($urandom(32'ha0dde3f5));
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		// reset values, unmapped and read-only places
		rd(ctl, 32'h0);
		rd(rld, 32'h0);
		rd(sta, 32'h10);
		bus(1'b0, 8'h18, 32'h0, {1'b1, 32'h0}, '1);
		wr(8'h18, 32'h5, 1'b1);
		wr(cnt, 32'h7);
		rd(cnt, 32'h0);
		$display("test reset finished");
		// period on rising then falling gate
		for (k = 0; k < 2; k++) begin
			n1 = 1 + $urandom % 5;
			arm(`CIM_MODE_PERIOD, k << 5);
			u_pins.pulse(pg, 1);
			u_pins.pulse(ps, n1);
			u_pins.pulse(pg, 1);
			settle();
			rd(lat, n1);
			rd(dat, n1);
			rd(sta, 32'h2, 32'h2);
		end
		$display("test period finished");
		// quadrature decoding, unarmed count holds the last period's value
		wr(ctl, 32'h2);
		u_pins.quad(1'b1, 2);
		settle();
		rd(cnt, n1);
		for (k = 1; k <= 3; k++) begin
			n1 = 2 + $urandom % 4;
			n2 = 1 + $urandom % 2;
			arm(k[2:0], 32'h0);
			u_pins.quad(1'b1, n1);
			u_pins.quad(1'b0, n2);
			settle();
			rd(cnt, (n1 - n2) << (k - 1));
		end
		$display("test quadrature finished");
		// two pulse encoder
		n1 = 1 + $urandom % 5;
		n2 = 1 + $urandom % 5;
		arm(`CIM_MODE_TWO_PULSE, 32'h0);
		u_pins.pulse(pa, n1);
		u_pins.pulse(pb, n2);
		settle();
		rd(cnt, n1 - n2);
		// clock enable low freezes sync stages and count
		@(posedge clk);
		ce <= 1'b0;
		u_pins.pulse(pa, 2);
		ce <= 1'b1;
		settle();
		rd(cnt, n1 - n2);
		$display("test two pulse finished");
		// index reload in phase 00 coinciding with a step
		rv = $urandom;
		wr(rld, rv);
		rd(rld, rv);
		arm(`CIM_MODE_QUAD_EDGE, 32'h800);
		u_pins.lvl(pa, 1'b1);
		u_pins.lvl(pb, 1'b1);
		u_pins.lvl(pa, 1'b0);
		// index held into the reload phase
		u_pins.lvl(pz, 1'b1);
		u_pins.lvl(pb, 1'b0);
		u_pins.lvl(pz, 1'b0);
		settle();
		rd(cnt, rv);
		u_pins.quad(1'b1, 1);
		settle();
		rd(cnt, rv + 32'h4);
		$display("test reload finished");
		// single separation on falling aux, later edges ignored
		n1 = 1 + $urandom % 4;
		n2 = 1 + $urandom % 4;
		arm(`CIM_MODE_SEP_SINGLE, 32'h40);
		u_pins.pulse(px, 1);
		u_pins.pulse(ps, n1);
		u_pins.pulse(px, 1);
		u_pins.pulse(ps, n2);
		u_pins.pulse(pg, 1);
		u_pins.pulse(px, 1);
		u_pins.pulse(ps, 2);
		u_pins.pulse(pg, 1);
		settle();
		check({32'h0, data_avail}, 33'h1);
		rd(lat, n1 + n2);
		rd(dat, n1 + n2);
		rd(dat, 32'h0);
		$display("test single separation finished");
		// implicit buffered separation on falling gate
		arm(`CIM_MODE_SEP_IMPLICIT, 32'h20);
		u_pins.pulse(px, 1);
		u_pins.pulse(ps, n1);
		u_pins.pulse(pg, 1);
		u_pins.pulse(px, 1);
		u_pins.pulse(ps, n2);
		u_pins.pulse(pg, 1);
		settle();
		rd(dat, n1);
		rd(dat, n2);
		$display("test implicit separation finished");
		// sample clocked separation and overrun
		arm(`CIM_MODE_SEP_SAMPLED, 32'h0);
		u_pins.pulse(px, 1);
		u_pins.pulse(ps, n1);
		u_pins.pulse(pg, 1);
		settle();
		rd(sta, 32'h10, 32'h10);
		u_pins.pulse(pp, 1);
		settle();
		rd(dat, n1);
		rd(sta, 32'h0, 32'h4);
		u_pins.pulse(pp, 1);
		settle();
		rd(sta, 32'h4, 32'h4);
		wr(sta, 32'h4);
		rd(sta, 32'h0, 32'h4);
		$display("test sampled separation finished");
		// buffered position on falling sample clock
		arm(`CIM_MODE_SINGLE_EDGE, 32'h180);
		u_pins.quad(1'b1, n1);
		u_pins.lvl(pp, 1'b1);
		u_pins.quad(1'b1, n2);
		u_pins.lvl(pp, 1'b0);
		settle();
		rd(dat, n1 + n2);
		rd(dat, 32'h0);
		rd(cnt, n1 + n2);
		$display("test buffered position finished");
		conclude();
	end
endmodule
`default_nettype wire
